// ---- shared/plipc_consts.svh ----
`ifndef PLIPC_CONSTS_SVH
`define PLIPC_CONSTS_SVH

// control line codes
`define PLIPC_CTL_IDLE 2'h0
`define PLIPC_CTL_HOLD 2'h1
`define PLIPC_CTL_XMIT 2'h2
`define PLIPC_CTL_RECV 2'h2
`define PLIPC_CTL_GRANT 2'h3
`define PLIPC_DATA_ZERO 8'h00
`define PLIPC_DATA_ON 8'hFF

// system clock and interface clock rates
`define PLIPC_CLK_NS 10
`define PLIPC_SYS_KHZ 64'd100000
`define PLIPC_IFCLK_KHZ 64'd49152
`define PLIPC_ACC_SPAN 64'd65536
`define PLIPC_IFCLK_INC 16'((64'd2 * `PLIPC_IFCLK_KHZ * `PLIPC_ACC_SPAN) / `PLIPC_SYS_KHZ)

// reset_recognition_time and disable_recognition_time, least values in ns
`define PLIPC_RST_MIN_NS 2600
`define PLIPC_DIS_MIN_NS 26030
`define PLIPC_RST_CYC 12'((`PLIPC_RST_MIN_NS + `PLIPC_CLK_NS - 1) / `PLIPC_CLK_NS)
`define PLIPC_DIS_CYC 12'((`PLIPC_DIS_MIN_NS + `PLIPC_CLK_NS - 1) / `PLIPC_CLK_NS)

// clock_activation_time from low power, least value in ns
`define PLIPC_WAKE_MIN_NS 5300000
`define PLIPC_WAKE_CYC ((`PLIPC_WAKE_MIN_NS + `PLIPC_CLK_NS - 1) / `PLIPC_CLK_NS)

// link-side hold limit and init sequence points, in interface clock cycles
`define PLIPC_HOLD_MAX 6'd47
`define PLIPC_INIT_FIRST 4'd1
`define PLIPC_INIT_RECV 4'd8
`define PLIPC_INIT_DONE 4'd9
`define PLIPC_IDLE_END_ACTIVE 2'd2
`define PLIPC_IDLE_END_NULL 2'd3

`endif

// ---- shared/plipc_pkg.sv ----
`default_nettype none
package plipc_pkg;

    typedef enum logic [2:0] {
        PH_DISABLED,
        PH_WAKE,
        PH_INIT,
        PH_OPER,
        PH_RESET
    } plipc_phase_e;

    typedef enum logic [2:0] {
        OWN_DEV,
        OWN_GRANT,
        OWN_HAND,
        OWN_LINK
    } plipc_own_e;

    typedef struct packed {
        logic [15:0] acc;
        logic tick;
    } plipc_div_s;

    typedef struct packed {
        plipc_phase_e phase;
        plipc_own_e own;
        logic [11:0] lowCnt;
        logic [19:0] wakeCnt;
        logic [3:0] initCnt;
        logic [5:0] holdCnt;
        logic [1:0] idleRun;
        logic sawActive;
        logic idleSeen;
        logic ifClk;
        logic ifClkOe;
        logic [1:0] ctl;
        logic ctlOe;
        logic [7:0] data;
        logic dataOe;
        logic linkReqValid;
        logic statusXferReq;
        logic cancelPending;
        logic lowPower;
        logic holdOverrun;
        logic devReady;
        logic operational;
    } plipc_state_s;

endpackage
`default_nettype wire

// ---- rtl/plipc_clk_div.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "plipc_consts.svh"

// phase accumulator: one tick per interface clock half period
module plipc_clk_div
    import plipc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic run,
    output logic tick
);
    plipc_div_s st_r;
    plipc_div_s st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (run) begin
            {st_nxt.tick, st_nxt.acc} = {1'b0, st_r.acc} + {1'b0, `PLIPC_IFCLK_INC};
        end else begin
            st_nxt = '0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tick = st_r.tick;
endmodule
`default_nettype wire

// ---- rtl/phy_link_iface_power_ctrl.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "plipc_consts.svh"

// What this block does
// - device idles one cycle after regaining interface
// - not operational: cancel requests, ignore link requests
// - status while non-operational is discarded
// - accept pulses within low/high time ranges
// - reset interface 2.60 to 2.68 us low
// - disable interface 26.03 to 26.11 us low
// - restart clock fast, or after low-power wake
// - reset: outputs zero, ignore link requests
// - isolation low: end at zero then float
// - isolation high: drive control and data low
// - disable also stops the interface clock
// - hardware reset leaves interface disabled
// - disabled with no active ports: low power
// - control codes idle hold transmit grant
// - interface clock is 49.152 MHz square wave
// - eighth cycle: receive with data-on, then idle
module phy_link_iface_power_ctrl
    import plipc_pkg::*;
#(
    parameter int unsigned WAKE_CYC = `PLIPC_WAKE_CYC
)
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic linkPowerStatus,
    input wire logic isoModeHigh,
    input wire logic portsActive,
    input wire logic linkRequestLine,
    input wire logic [1:0] ctlIn,
    input wire logic grantReq,
    input wire logic statusEvent,
    input wire logic statusTaken,
    output logic [1:0] ctlOut,
    output logic ctlOe,
    output logic [7:0] dataOut,
    output logic dataOe,
    output logic ifClkOut,
    output logic ifClkOe,
    output logic ifaceOperational,
    output logic devReady,
    output logic linkReqValid,
    output logic statusXferReq,
    output logic cancelPendingReq,
    output logic lowPower,
    output logic linkHoldOverrun
);
    plipc_state_s st_r;
    plipc_state_s st_nxt;
    logic tick;
    logic ifRise;

    function automatic logic clkRuns(input plipc_phase_e ph);
        clkRuns = (ph == PH_INIT) || (ph == PH_OPER) || (ph == PH_RESET);
    endfunction

    plipc_clk_div u_div (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .run(clkRuns(st_r.phase)),
        .tick(tick)
    );

    assign ifRise = tick && !st_r.ifClk;

    always_comb begin
        st_nxt = st_r;
        st_nxt.cancelPending = 1'b0;
        // a high sample clears the window, so pulse trains count as asserted
        if (linkPowerStatus) begin
            st_nxt.lowCnt = '0;
        end else if (st_r.lowCnt != `PLIPC_DIS_CYC) begin
            st_nxt.lowCnt = st_r.lowCnt + 12'h001;
        end
        unique case (st_r.phase)
            PH_DISABLED: begin
                if (linkPowerStatus) begin
                    // from low power the oscillator needs the long wake
                    st_nxt.phase = st_r.lowPower ? PH_WAKE : PH_INIT;
                    st_nxt.wakeCnt = '0;
                    st_nxt.initCnt = '0;
                end
            end
            PH_WAKE: begin
                st_nxt.wakeCnt = st_r.wakeCnt + 20'h00001;
                if (!linkPowerStatus && st_r.lowCnt == `PLIPC_RST_CYC - 12'h001) begin
                    st_nxt.phase = PH_DISABLED;
                end else if (32'(st_r.wakeCnt) >= WAKE_CYC - 1) begin
                    st_nxt.phase = PH_INIT;
                    st_nxt.initCnt = '0;
                end
            end
            PH_INIT, PH_OPER: begin
                if (!linkPowerStatus && st_r.lowCnt == `PLIPC_RST_CYC - 12'h001) begin
                    st_nxt.phase = PH_RESET;
                end else if (st_r.phase == PH_INIT && ifRise) begin
                    st_nxt.initCnt = st_r.initCnt + 4'h1;
                    if (st_r.initCnt == `PLIPC_INIT_DONE - 4'h1) begin
                        st_nxt.phase = PH_OPER;
                        st_nxt.own = OWN_DEV;
                        st_nxt.idleSeen = 1'b0;
                    end
                end
            end
            PH_RESET: begin
                if (linkPowerStatus) begin
                    st_nxt.phase = PH_INIT;
                    st_nxt.initCnt = '0;
                end else if (st_r.lowCnt == `PLIPC_DIS_CYC - 12'h001) begin
                    st_nxt.phase = PH_DISABLED;
                end
            end
            default: st_nxt.phase = PH_DISABLED;
        endcase

        // interface ownership while operational, stepped on interface clock edges
        if (st_r.phase == PH_OPER && st_nxt.phase == PH_OPER && ifRise) begin
            unique case (st_r.own)
                OWN_DEV: begin
                    st_nxt.idleSeen = 1'b1;
                    if (grantReq && st_r.idleSeen) begin
                        st_nxt.own = OWN_GRANT;
                    end
                end
                OWN_GRANT: st_nxt.own = OWN_HAND;
                OWN_HAND: begin
                    st_nxt.own = OWN_LINK;
                    st_nxt.holdCnt = '0;
                    st_nxt.idleRun = '0;
                    st_nxt.sawActive = 1'b0;
                end
                OWN_LINK: begin
                    if (ctlIn == `PLIPC_CTL_IDLE) begin
                        st_nxt.idleRun = st_r.idleRun + 2'd1;
                        // two idles after activity, or three with none, hand back
                        if ((st_r.sawActive && st_r.idleRun == `PLIPC_IDLE_END_ACTIVE - 2'd1)
                                || st_r.idleRun == `PLIPC_IDLE_END_NULL - 2'd1) begin
                            st_nxt.own = OWN_DEV;
                            st_nxt.idleSeen = 1'b0;
                        end
                    end else begin
                        st_nxt.idleRun = '0;
                        st_nxt.sawActive = 1'b1;
                        if (ctlIn == `PLIPC_CTL_HOLD) begin
                            if (st_r.holdCnt == `PLIPC_HOLD_MAX) begin
                                st_nxt.holdOverrun = 1'b1;
                            end else begin
                                st_nxt.holdCnt = st_r.holdCnt + 6'd1;
                            end
                        end
                    end
                end
                default: st_nxt.own = OWN_DEV;
            endcase
        end
        if (st_nxt.phase != PH_OPER) begin
            st_nxt.own = OWN_DEV;
            st_nxt.idleSeen = 1'b0;
        end

        // interface clock
        if (!clkRuns(st_nxt.phase)) begin
            st_nxt.ifClk = 1'b0;
        end else if (tick) begin
            st_nxt.ifClk = !st_r.ifClk;
        end
        st_nxt.ifClkOe = clkRuns(st_nxt.phase) || isoModeHigh;

        // control and data lines
        st_nxt.ctl = `PLIPC_CTL_IDLE;
        st_nxt.data = `PLIPC_DATA_ZERO;
        st_nxt.ctlOe = isoModeHigh;
        if (st_nxt.phase == PH_RESET || st_nxt.phase == PH_DISABLED) begin
            // one cycle driving zero before floating, so the lines settle low
            if (st_r.phase != PH_RESET && st_r.phase != PH_DISABLED) begin
                st_nxt.ctlOe = 1'b1;
            end
        end else if (st_nxt.phase == PH_INIT) begin
            if (st_nxt.initCnt == `PLIPC_INIT_FIRST) begin
                st_nxt.ctlOe = 1'b1;
            end else if (st_nxt.initCnt == `PLIPC_INIT_RECV) begin
                st_nxt.ctl = `PLIPC_CTL_RECV;
                st_nxt.data = `PLIPC_DATA_ON;
                st_nxt.ctlOe = 1'b1;
            end
        end else if (st_nxt.phase == PH_OPER) begin
            st_nxt.ctlOe = (st_nxt.own != OWN_LINK);
            if (st_nxt.own == OWN_GRANT) begin
                st_nxt.ctl = `PLIPC_CTL_GRANT;
            end
        end
        st_nxt.dataOe = st_nxt.ctlOe;

        st_nxt.devReady = st_nxt.phase == PH_OPER && st_nxt.own == OWN_DEV && st_nxt.idleSeen;
        st_nxt.operational = st_nxt.phase == PH_OPER;
        st_nxt.linkReqValid = (st_r.phase == PH_OPER) && linkRequestLine;
        if (st_r.phase == PH_OPER && st_nxt.phase != PH_OPER) begin
            st_nxt.cancelPending = 1'b1;
        end
        // new events win over the acknowledge; anything outside operation is dropped
        st_nxt.statusXferReq = (st_r.phase == PH_OPER)
            && (statusEvent || (st_r.statusXferReq && !statusTaken));
        st_nxt.lowPower = (st_nxt.phase == PH_DISABLED && !portsActive)
            || st_nxt.phase == PH_WAKE;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            st_r <= '0;
            st_r.phase <= PH_DISABLED;
            st_r.own <= OWN_DEV;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign ctlOut = st_r.ctl;
    assign ctlOe = st_r.ctlOe;
    assign dataOut = st_r.data;
    assign dataOe = st_r.dataOe;
    assign ifClkOut = st_r.ifClk;
    assign ifClkOe = st_r.ifClkOe;
    assign ifaceOperational = st_r.operational;
    assign devReady = st_r.devReady;
    assign linkReqValid = st_r.linkReqValid;
    assign statusXferReq = st_r.statusXferReq;
    assign cancelPendingReq = st_r.cancelPending;
    assign lowPower = st_r.lowPower;
    assign linkHoldOverrun = st_r.holdOverrun;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    a_reset_entry: assert property ((st_r.phase == PH_OPER && !linkPowerStatus
        && st_r.lowCnt == `PLIPC_RST_CYC - 12'h001) |=> st_r.phase == PH_RESET)
        else $error("interface reset not entered on time");
    a_no_early_reset: assert property ($rose(st_r.phase == PH_RESET)
        |-> $past(st_r.lowCnt) == `PLIPC_RST_CYC - 12'h001)
        else $error("interface reset entered early");
    a_disable_entry: assert property ((st_r.phase == PH_RESET && !linkPowerStatus
        && st_r.lowCnt == `PLIPC_DIS_CYC - 12'h001) |=> st_r.phase == PH_DISABLED && !ifClkOut)
        else $error("interface not disabled on time");
    a_reset_lines_low: assert property (st_r.phase == PH_RESET
        |-> ctlOut == `PLIPC_CTL_IDLE && dataOut == `PLIPC_DATA_ZERO)
        else $error("lines not zero in reset");
    a_request_ignored: assert property (!ifaceOperational |=> !linkReqValid)
        else $error("link request passed while not operational");
    a_status_discard: assert property (!ifaceOperational |=> !statusXferReq)
        else $error("status kept while not operational");
    a_iso_high_drive: assert property ((st_r.phase == PH_RESET && isoModeHigh)
        ##1 (st_r.phase == PH_RESET && isoModeHigh) |-> ctlOe && dataOe)
        else $error("lines not driven low in reset");
    a_iso_low_float: assert property ((st_r.phase == PH_RESET && !isoModeHigh)[*3]
        |-> !ctlOe && !dataOe)
        else $error("lines not floated in reset");
    a_regain_idle: assert property ($rose(devReady)
        |-> ctlOe && ctlOut == `PLIPC_CTL_IDLE && $past(ctlOe) && $past(ctlOut) == `PLIPC_CTL_IDLE)
        else $error("ready without an idle cycle");
    a_clock_stopped: assert property (st_r.phase == PH_DISABLED |-> !ifClkOut)
        else $error("interface clock runs while disabled");
    a_fast_restart: assert property ((st_r.phase == PH_DISABLED && !lowPower
        && linkPowerStatus) |=> st_r.phase == PH_INIT ##[1:4] tick)
        else $error("interface clock not restarted");
    a_low_power: assert property ((st_r.phase == PH_DISABLED && !portsActive)
        ##1 (st_r.phase == PH_DISABLED) |-> lowPower)
        else $error("low power not entered");
    a_init_receive: assert property ((st_r.phase == PH_INIT
        && ctlOut == `PLIPC_CTL_RECV) |-> dataOut == `PLIPC_DATA_ON
        && st_r.initCnt == `PLIPC_INIT_RECV)
        else $error("receive code at wrong init cycle");
endmodule
`default_nettype wire

// ---- tb/plipc_link_model.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "plipc_consts.svh"

// link controller facing the device across the control lines
module plipc_link_model
    import plipc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic ifClk,
    input wire logic [1:0] ctlOut,
    input wire logic ctlOe,
    output logic [1:0] ctlIn,
    output logic link_power_status
);
    logic [1:0] drvCode = 2'h0;
    logic drvOn = 1'b0;
    logic [1:0] lastWire = 2'h0;

    initial link_power_status = 1'b0;
    // undriven lines toggle, so a stale code is never read as a real one
    assign ctlIn = ctlOe ? ctlOut : (drvOn ? drvCode : ~lastWire);
    always @(posedge sys_clk) lastWire <= ctlIn;

    task automatic pulse(input int lo, input int hi, input int n);
        repeat (n) begin
            link_power_status = 1'b0;
            repeat (lo) @(posedge sys_clk);
            #1 link_power_status = 1'b1;
            repeat (hi) @(posedge sys_clk);
            #1;
        end
    endtask

    // optional lead idle, hold cycles, closing idles, then release
    task automatic xfer(input int lead, input int nHold, input int nIdle);
        int i;
        for (i = 0; i < 8 && ctlOe !== 1'b0; i++) begin
            @(posedge ifClk);
            #1;
        end
        drvOn = 1'b1;
        for (i = 0; i < lead + nHold + nIdle; i++) begin
            drvCode = (i < lead || i >= lead + nHold) ? `PLIPC_CTL_IDLE : `PLIPC_CTL_HOLD;
            @(posedge ifClk);
            #1;
        end
        drvOn = 1'b0;
    endtask
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "plipc_consts.svh"

module tb
    import plipc_pkg::*;
;
    localparam logic [31:0] YES = 32'h1;
    localparam logic [31:0] NO = 32'h0;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic isoModeHigh = 1'b0;
    logic portsActive = 1'b0;
    logic linkRequestLine = 1'b0;
    logic grantReq = 1'b0;
    logic statusEvent = 1'b0;
    logic statusTaken = 1'b0;
    logic opDrop = 1'b0;
    logic linkPowerStatus, ctlOe, dataOe, ifClkOut, ifClkOe, ifaceOperational, devReady;
    logic linkReqValid, statusXferReq, cancelPendingReq, lowPower, linkHoldOverrun;
    logic [1:0] ctlIn, ctlOut;
    logic [7:0] dataOut;
    int fail_count = 0;
    int n_checks = 0;

    phy_link_iface_power_ctrl #(.WAKE_CYC(20)) dut_u (
        .sys_clk, .rst_b, .linkPowerStatus, .isoModeHigh, .portsActive, .linkRequestLine,
        .ctlIn, .grantReq, .statusEvent, .statusTaken, .ctlOut, .ctlOe, .dataOut,
        .dataOe, .ifClkOut, .ifClkOe, .ifaceOperational, .devReady, .linkReqValid,
        .statusXferReq, .cancelPendingReq, .lowPower, .linkHoldOverrun
    );
    plipc_link_model link_u (
        .sys_clk, .ifClk(ifClkOut), .ctlOut, .ctlOe, .ctlIn, .link_power_status(linkPowerStatus)
    );

    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) if (ifaceOperational !== 1'b1) opDrop <= 1'b1;

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic waitlim(input int i, input int lim);
        if (i >= lim) begin
            fail_count++;
            report_and_stop();
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    // bounded wait for the next interface clock rise
    task automatic rise;
        int k;
        logic p;
        p = ifClkOut;
        for (k = 0; k < 8 && !(p === 1'b0 && ifClkOut === 1'b1); k++) begin
            p = ifClkOut;
            cyc(1);
        end
        waitlim(k, 8);
    endtask

    // raise power status, then follow the init walk rise by rise
    task automatic bringup(input int lo, input int hi);
        int n, r, rcv;
        longint t0;
        logic prev;
        rcv = 0;
        t0 = 0;
        link_u.link_power_status = 1'b1;
        // a rise at the edge that samples the raised status predates init
        cyc(1);
        prev = ifClkOut;
        for (n = 2; n <= hi; n++) begin
            cyc(1);
            if (prev === 1'b0 && ifClkOut === 1'b1) break;
            prev = ifClkOut;
        end
        check(32'(n >= lo && n <= hi), YES);
        for (r = 2; r <= 12; r++) begin
            rise();
            if (r == 2) t0 = $time;
            if ({ctlOe, ctlOut, dataOut} === {1'b1, `PLIPC_CTL_RECV, `PLIPC_DATA_ON}) rcv = r;
        end
        // ten periods, the whole span may slip by one system clock in all
        check(32'($time - t0 >= 200 && $time - t0 <= 210), YES);
        check(rcv, 32'h8);
        check({ifaceOperational, ctlOut, dataOut}, {1'b1, 10'h0});
        for (n = 0; n < 50 && devReady !== 1'b1; n++) cyc(1);
        waitlim(n, 50);
    endtask

    task automatic t_hwreset;
        cyc(2);
        check({ifaceOperational, ctlOe, dataOe, ifClkOe}, NO);
        check(lowPower, YES);
        bringup(20, 30);
        $display("test hwreset done");
    endtask

    task automatic t_reset(input logic iso);
        int n;
        logic sawCancel;
        isoModeHigh = iso;
        linkRequestLine = 1'b1;
        sawCancel = 1'b0;
        cyc(2);
        check(linkReqValid, YES);
        statusEvent = 1'b1;
        cyc(1);
        statusEvent = 1'b0;
        check(statusXferReq, YES);
        statusTaken = 1'b1;
        cyc(1);
        statusTaken = 1'b0;
        check(statusXferReq, NO);
        // left pending on purpose: leaving operation must drop it
        statusEvent = 1'b1;
        cyc(1);
        statusEvent = 1'b0;
        check(statusXferReq, YES);
        link_u.link_power_status = 1'b0;
        for (n = 0; n < 300 && ifaceOperational !== 1'b0; n++) begin
            cyc(1);
            sawCancel |= cancelPendingReq;
        end
        check(32'(n >= 260 && n <= 268), YES);
        check(sawCancel, YES);
        check({ctlOut, dataOut}, NO);
        cyc(2);
        check({ctlOe, dataOe, ctlOut, dataOut}, {iso, iso, 10'h0});
        // the last operational sample of the request line drains one cycle after entry
        check(linkReqValid, NO);
        statusEvent = 1'b1;
        cyc(1);
        statusEvent = 1'b0;
        cyc(1);
        check(statusXferReq, NO);
        linkRequestLine = 1'b0;
        cyc(1500);
        bringup(0, 9);
        check(statusXferReq, NO);
        $display("test reset iso %0d done", iso);
    endtask

    task automatic t_pulse;
        opDrop = 1'b0;
        link_u.pulse(255, 70, 3);
        link_u.pulse(12, 3, 6);
        check(opDrop, NO);
        $display("test pulse done");
    endtask

    task automatic t_xfer(input int lead, input int nHold, input int nIdle,
        input logic [31:0] ovr);
        int i;
        grantReq = 1'b1;
        for (i = 0; i < 20 && ctlOut !== `PLIPC_CTL_GRANT; i++) rise();
        waitlim(i, 20);
        grantReq = 1'b0;
        check(ctlOe, YES);
        rise();
        check({ctlOe, ctlOut}, {1'b1, `PLIPC_CTL_IDLE});
        link_u.xfer(lead, nHold, nIdle);
        for (i = 0; i < 100 && ctlOe !== 1'b1; i++) cyc(1);
        waitlim(i, 100);
        check({ctlOut, devReady}, NO);
        for (i = 0; i < 100 && devReady !== 1'b1; i++) cyc(1);
        waitlim(i, 100);
        check({ctlOe, ctlOut}, {1'b1, `PLIPC_CTL_IDLE});
        check(linkHoldOverrun, ovr);
        $display("test xfer %0d %0d %0d done", lead, nHold, nIdle);
    endtask

    task automatic t_disable;
        int n;
        isoModeHigh = 1'b0;
        portsActive = 1'b1;
        link_u.link_power_status = 1'b0;
        for (n = 0; n < 2700 && ifClkOe !== 1'b0; n++) cyc(1);
        check(32'(n >= 2603 && n <= 2611), YES);
        check({ctlOe, dataOe, lowPower, ifaceOperational}, NO);
        bringup(0, 9);
        $display("test disable done");
    endtask

    initial begin
        cyc(4);
        rst_b = 1'b1;
        t_hwreset();
        t_reset(1'b0);
        t_reset(1'b1);
        t_pulse();
        t_xfer(0, 0, 3, NO);
        t_xfer(0, 5, 2, NO);
        t_xfer(1, 47, 2, NO);
        t_disable();
        // overrun flag is sticky, so this case runs last
        t_xfer(0, 48, 2, YES);
        report_and_stop();
    end

    initial begin
        repeat (60000) @(posedge sys_clk);
        fail_count++;
        report_and_stop();
    end
endmodule
`default_nettype wire
